/* design/cslp_core.sv */
// Status word, interrupt mode save and clock gating with AXI4-Lite registers
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cslp_core #(
	parameter bit XTAL_OFF_ALLOWED = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire cslp_pkg::cslp_axi_req_t axi_in,
	output cslp_pkg::cslp_axi_rsp_t axi_out,
	input wire logic irq_pin,
	input wire logic xtal_pin,
	output cslp_pkg::cslp_clk_t gates,
	output logic irq_ack
);
	typedef enum logic {ST_ACTIVE, ST_HANDLER} cslp_state_t;
	localparam logic [7:0] DCO_CYC = 8'(cslp_pkg::DCO_RESTART_CYC);
	localparam int DLY_MIN = 1;
	localparam int DLY_MAX = 21;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && ((a <= cslp_pkg::ADDR_CLKSTAT) ||
			((a >= cslp_pkg::ADDR_REGFILE) && (a <= cslp_pkg::ADDR_REGEND)));
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	function automatic cslp_pkg::cslp_fmt_t fmt_of(input logic [15:0] op);
		if (op[15:13] == cslp_pkg::OP_JUMP_TAG) begin
			fmt_of = cslp_pkg::FMT_JUMP;
		end else if (op[15:12] == cslp_pkg::OP_SINGLE_TAG) begin
			fmt_of = cslp_pkg::FMT_SINGLE;
		end else begin
			fmt_of = cslp_pkg::FMT_DUAL;
		end
	endfunction

	// ====================================================================
	// Pin synchronisers
	logic irq_s1, irq_s2, xt_s1, xt_s2, xt_s3;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{irq_s1, irq_s2, xt_s1, xt_s2, xt_s3} <= 5'h00;
		end else begin
			{irq_s1, irq_s2} <= {irq_pin, irq_s1};
			{xt_s1, xt_s2, xt_s3} <= {xtal_pin, xt_s1, xt_s2};
		end
	end

	// ====================================================================
	// AXI4-Lite slave
	logic aw_rdy, w_rdy, aw_held, w_held, bvalid, ar_rdy, rvalid;
	logic [7:0] aw_addr;
	logic [31:0] w_data, rdata;
	logic [3:0] w_strb;
	logic [1:0] bresp, rresp;
	wire aw_take = axi_in.awvalid && aw_rdy;
	wire w_take = axi_in.wvalid && w_rdy;
	wire wr_fire = aw_held && w_held && !bvalid;
	wire next_aw_held = (aw_held && !wr_fire) || aw_take;
	wire next_w_held = (w_held && !wr_fire) || w_take;
	wire ar_take = axi_in.arvalid && ar_rdy;
	wire next_rvalid = ar_take || (rvalid && !axi_in.rready);
	wire wr_ok = wr_fire && addr_ok(aw_addr);
	wire wr_reg = wr_ok && (aw_addr >= cslp_pkg::ADDR_REGFILE);
	wire [3:0] wr_idx = aw_addr[5:2];
	wire wr_sw = wr_reg && (wr_idx == cslp_pkg::REG_SW);
	wire wr_cmd = wr_ok && (aw_addr == cslp_pkg::ADDR_CMD) && w_strb[0];
	wire wr_sel = wr_ok && (aw_addr == cslp_pkg::ADDR_CLKSEL) && w_strb[0];
	wire wr_stk = wr_ok && (aw_addr == cslp_pkg::ADDR_STACKED);
	wire wr_op = wr_ok && (aw_addr == cslp_pkg::ADDR_OPWORD);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{aw_rdy, w_rdy, aw_held, w_held, bvalid} <= 5'h00;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bresp <= cslp_pkg::RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_rdy <= !next_aw_held;
			w_rdy <= !next_w_held;
			if (aw_take) begin
				aw_addr <= axi_in.awaddr;
			end
			if (w_take) begin
				w_data <= axi_in.wdata;
				w_strb <= axi_in.wstrb;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_ok ? cslp_pkg::RESP_OKAY : cslp_pkg::RESP_SLVERR;
			end else if (axi_in.bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ====================================================================
	// Core state
	logic [15:0] sw, stacked, opword;
	logic [15:0] regs [0:cslp_pkg::NUM_REGS-1];
	logic [2:0] clksel;
	logic op_pend;
	cslp_pkg::cslp_fmt_t last_fmt;
	cslp_state_t state;
	wire [1:0] main_clock_select = clksel[1:0];
	wire subsystem_clock_select = clksel[2];

	wire irq_accept = irq_s2 && sw[cslp_pkg::SW_GIE] && (state == ST_ACTIVE);
	wire interrupt_return_instr_fire = wr_cmd && w_data[cslp_pkg::CMD_INTERRUPT_RETURN_INSTR_BIT] && (state == ST_HANDLER)
		&& !irq_accept;
	wire [15:0] sw_restore = stacked & cslp_pkg::SW_IMPL_MASK;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_ACTIVE;
			irq_ack <= 1'b0;
		end else begin
			irq_ack <= irq_accept;
			case (state)
				ST_ACTIVE: begin
					if (irq_accept) begin
						state <= ST_HANDLER;
					end
				end
				ST_HANDLER: begin
					if (interrupt_return_instr_fire) begin
						state <= ST_ACTIVE;
					end
				end
				default: state <= ST_ACTIVE;
			endcase
		end
	end

	// Hardware entry wins over a software write in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sw <= cslp_pkg::SW_RESET;
			stacked <= cslp_pkg::SW_RESET;
		end else if (irq_accept) begin
			stacked <= sw;
			sw <= sw & ~cslp_pkg::SW_WAKE_CLR;
		end else begin
			if (interrupt_return_instr_fire) begin
				sw <= sw_restore;
			end else if (wr_sw) begin
				sw <= merge(sw, w_data, w_strb) & cslp_pkg::SW_IMPL_MASK;
			end
			if (wr_stk) begin
				stacked <= merge(stacked, w_data, w_strb) & cslp_pkg::SW_IMPL_MASK;
			end
		end
	end

	// ====================================================================
	// Register file and one-cycle register ops
	wire [3:0] op_src = opword[11:8];
	wire [3:0] op_dst = opword[3:0];
	wire op_byte = opword[cslp_pkg::OP_BYTE_BIT];
	wire op_is_add = opword[15:12] == cslp_pkg::OP_ADD;
	wire op_known = op_is_add || (opword[15:12] == cslp_pkg::OP_MOV);
	wire [15:0] op_sum = regs[op_src] + regs[op_dst];
	wire [15:0] op_raw = op_is_add ? op_sum : regs[op_src];
	wire [15:0] op_res = op_byte ? (op_raw & cslp_pkg::BYTE_MASK) : op_raw;
	wire op_go = op_pend && op_known && (op_dst != cslp_pkg::REG_SW)
		&& (op_dst != cslp_pkg::REG_CG);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			opword <= 16'h0000;
			op_pend <= 1'b0;
			last_fmt <= cslp_pkg::FMT_DUAL;
		end else begin
			op_pend <= wr_op && (fmt_of(merge(opword, w_data, w_strb)) == cslp_pkg::FMT_DUAL);
			if (wr_op) begin
				opword <= merge(opword, w_data, w_strb);
				last_fmt <= fmt_of(merge(opword, w_data, w_strb));
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < cslp_pkg::NUM_REGS; i++) begin
				regs[i] <= 16'h0000;
			end
			regs[cslp_pkg::REG_SP] <= cslp_pkg::SP_RESET;
		end else begin
			if (op_go) begin
				regs[op_dst] <= op_res;
			end else if (wr_reg && wr_idx != cslp_pkg::REG_SW && wr_idx != cslp_pkg::REG_CG) begin
				regs[wr_idx] <= merge(regs[wr_idx], w_data, w_strb);
			end
			if (irq_accept) begin
				regs[cslp_pkg::REG_SP] <= regs[cslp_pkg::REG_SP] - cslp_pkg::STACK_STEP;
			end else if (interrupt_return_instr_fire) begin
				regs[cslp_pkg::REG_SP] <= regs[cslp_pkg::REG_SP] + cslp_pkg::STACK_STEP;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clksel <= 3'h0;
		end else if (wr_sel) begin
			clksel <= w_data[2:0];
		end
	end

	// ====================================================================
	// Clock gating
	logic gen_on, dco_ready;
	logic [7:0] dco_cnt;
	wire cpu_on = !sw[cslp_pkg::SW_COFF];
	wire sub_on = !sw[cslp_pkg::SW_SCG];
	wire dco_used_m = cpu_on && !main_clock_select[1];
	wire dco_used_s = sub_on && !subsystem_clock_select;
	wire xt_used = (cpu_on && (main_clock_select == 2'h3)) || (sub_on && subsystem_clock_select);
	wire next_gen_on = !sw[cslp_pkg::SW_DCG] || dco_used_m || dco_used_s;
	wire next_xt_on = !sw[cslp_pkg::SW_XOFF] || !XTAL_OFF_ALLOWED || xt_used;
	wire next_dco_ready = gen_on && (dco_cnt == 8'h00);
	wire aux_edge = xt_s2 && !xt_s3 && gates.crystal_osc_on;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gen_on <= 1'b1;
			dco_cnt <= 8'h00;
			dco_ready <= 1'b0;
		end else begin
			gen_on <= next_gen_on;
			dco_ready <= next_dco_ready;
			if (next_gen_on && !gen_on) begin
				dco_cnt <= DCO_CYC;
			end else if (dco_cnt != 8'h00) begin
				dco_cnt <= dco_cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gates <= '0;
		end else begin
			gates.main_clock_run <= cpu_on && (main_clock_select[1] || dco_ready);
			gates.peripheral_subsystem_clock_run <= sub_on && (subsystem_clock_select || dco_ready);
			gates.aux_clock_tick <= aux_edge;
			gates.dc_generator_on <= next_gen_on;
			gates.digital_osc_clock_on <= dco_used_m;
			gates.crystal_osc_on <= next_xt_on;
		end
	end

	// ====================================================================
	// Read path
	// bus-mapped registers
	wire [7:0] ra = axi_in.araddr;
	wire [3:0] r_idx = ra[5:2];
	wire [15:0] reg_rd = (r_idx == cslp_pkg::REG_SW) ? sw :
		(r_idx == cslp_pkg::REG_CG) ? cslp_pkg::CG_VALUE : regs[r_idx];
	wire [31:0] rd_word =
		(ra >= cslp_pkg::ADDR_REGFILE) ? {16'h0000, reg_rd} :
		(ra == cslp_pkg::ADDR_CMD) ? {31'h0000_0000, state == ST_HANDLER} :
		(ra == cslp_pkg::ADDR_CLKSEL) ? {29'h0000_0000, clksel} :
		(ra == cslp_pkg::ADDR_STACKED) ? {16'h0000, stacked} :
		(ra == cslp_pkg::ADDR_OPWORD) ? {14'h0000, last_fmt, opword} :
		{25'h0000_0000, dco_ready, gates};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{ar_rdy, rvalid} <= 2'h0;
			rdata <= 32'h0000_0000;
			rresp <= cslp_pkg::RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			ar_rdy <= !next_rvalid;
			if (ar_take) begin
				rdata <= addr_ok(ra) ? rd_word : 32'h0000_0000;
				rresp <= addr_ok(ra) ? cslp_pkg::RESP_OKAY : cslp_pkg::RESP_SLVERR;
			end
		end
	end

	assign axi_out = '{awready: aw_rdy, wready: w_rdy, bvalid: bvalid, bresp: bresp,
		arready: ar_rdy, rvalid: rvalid, rdata: rdata, rresp: rresp};

	// ====================================================================
	// Checks
	property p_sub_gate;
		@(posedge clk) disable iff (sys_rst)
		sw[cslp_pkg::SW_SCG] |=> !gates.peripheral_subsystem_clock_run;
	endproperty
	a_sub_gate: assert property (p_sub_gate) else $error("subsystem clock ran while gated");
	property p_cpu_gate;
		@(posedge clk) disable iff (sys_rst)
		sw[cslp_pkg::SW_COFF] |=> !gates.main_clock_run;
	endproperty
	a_cpu_gate: assert property (p_cpu_gate) else $error("cpu clock ran while off");
	property p_gen_hold;
		@(posedge clk) disable iff (sys_rst)
		(dco_used_m || dco_used_s) |=> gates.dc_generator_on;
	endproperty
	a_gen_hold: assert property (p_gen_hold) else $error("generator stopped while used");
	property p_gen_stop;
		@(posedge clk) disable iff (sys_rst)
		(sw[cslp_pkg::SW_DCG] && !dco_used_m && !dco_used_s) |=> !gates.dc_generator_on;
	endproperty
	a_gen_stop: assert property (p_gen_stop) else $error("generator not stopped");
	property p_dco_out;
		@(posedge clk) disable iff (sys_rst)
		gates.digital_osc_clock_on |-> $past(cpu_on) && !$past(main_clock_select[1]);
	endproperty
	a_dco_out: assert property (p_dco_out) else $error("oscillator clock on unselected");
	property p_restart;
		@(posedge clk) disable iff (sys_rst)
		$rose(gen_on) |-> !dco_ready ##[DLY_MIN:DLY_MAX] dco_ready;
	endproperty
	a_restart: assert property (p_restart) else $error("restart delay wrong");
	property p_xtal;
		@(posedge clk) disable iff (sys_rst)
		(!sw[cslp_pkg::SW_XOFF] || xt_used) |=> gates.crystal_osc_on;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal stopped while needed");
	property p_push;
		@(posedge clk) disable iff (sys_rst)
		irq_accept |=> (stacked == $past(sw)) && (sw[7:3] == 5'h00) && irq_ack;
	endproperty
	a_push: assert property (p_push) else $error("status not saved on entry");
	property p_interrupt_return_instr;
		@(posedge clk) disable iff (sys_rst)
		interrupt_return_instr_fire |=> (sw == $past(sw_restore)) && (state == ST_ACTIVE);
	endproperty
	a_interrupt_return_instr: assert property (p_interrupt_return_instr) else $error("saved status not restored");
	property p_gie;
		@(posedge clk) disable iff (sys_rst)
		$rose(state == ST_HANDLER) |-> $past(sw[cslp_pkg::SW_GIE]);
	endproperty
	a_gie: assert property (p_gie) else $error("interrupt taken while disabled");
	property p_resv;
		@(posedge clk) disable iff (sys_rst)
		wr_sw |=> sw[15:9] == 7'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved status bits set");
	c_entry: cover property (@(posedge clk) disable iff (sys_rst) irq_accept ##[1:50] interrupt_return_instr_fire);
	c_gen_off: cover property (@(posedge clk) disable iff (sys_rst) $fell(gen_on));
	c_op: cover property (@(posedge clk) disable iff (sys_rst) op_go && op_byte);
	c_xt_off: cover property (@(posedge clk) disable iff (sys_rst) $fell(gates.crystal_osc_on));
endmodule

/* shared/cslp_pkg.sv */
// Constants and carrier types for the status word and low-power control block
// ====================================================================
// Operation
// - Sixteen registers live inside the block; register ops finish in one cycle.
// - Index 0 to 3 are pc, stack pointer, status word, constant; twelve general.
// - Non-jump ops are register ops; seven source and four destination modes exist.
// - Decoder knows 51 instructions in dual, single and jump formats.
// - Instructions work on words, or on bytes when the byte form is chosen.
// - Any accepted interrupt wakes the core; return restores the earlier mode.
// - Accepting an interrupt saves the whole status word with its low-power bits.
// - A changed saved status word takes effect on return.
// - Bits 7,6,5,4 gate subsystem clock, dc generator, crystal, cpu clock; reset clear.
// - Subsystem clock runs while its gate bit is clear, stops while set.
// - Dc generator stops only if gated and unused by main and subsystem clocks.
// - Oscillator output clock is off unless it feeds the cpu clock.
// - Gate bit cannot stop generator while cpu or subsystem clock uses it.
// - Oscillator restart after generator stop is delayed by a short time.
// - Crystal stops only if its off bit is set and no clock uses it.
// - A build option can forbid stopping the crystal at all.
// - Cpu clock runs while its off bit is clear, stops while set.
// - Three clocks: crystal auxiliary, main, and subsystem.
// - Registers sit on an address, data and control bus.
package cslp_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned DCO_RESTART_NS = 1000;
	localparam int unsigned DCO_RESTART_CYC =
		(DCO_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned NUM_REGS = 16;
	localparam int unsigned NUM_GP_REGS = 12;
	localparam int unsigned SRC_MODES = 7;
	localparam int unsigned DST_MODES = 4;
	localparam int unsigned NUM_INSTR = 51;
	// ====================================================================
	// Register map
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_CLKSEL = 8'h04;
	localparam logic [7:0] ADDR_STACKED = 8'h08;
	localparam logic [7:0] ADDR_OPWORD = 8'h0C;
	localparam logic [7:0] ADDR_CLKSTAT = 8'h10;
	localparam logic [7:0] ADDR_REGFILE = 8'h40;
	localparam logic [7:0] ADDR_REGEND = 8'h7C;
	localparam int unsigned CMD_INTERRUPT_RETURN_INSTR_BIT = 0;
	// ====================================================================
	// Status word fields
	localparam int unsigned SW_SCG = 7;
	localparam int unsigned SW_DCG = 6;
	localparam int unsigned SW_XOFF = 5;
	localparam int unsigned SW_COFF = 4;
	localparam int unsigned SW_GIE = 3;
	localparam logic [15:0] SW_RESET = 16'h0000;
	localparam logic [15:0] SW_IMPL_MASK = 16'h01FF;
	localparam logic [15:0] SW_WAKE_CLR = 16'h00F8;
	localparam logic [3:0] REG_PC = 4'h0;
	localparam logic [3:0] REG_SP = 4'h1;
	localparam logic [3:0] REG_SW = 4'h2;
	localparam logic [3:0] REG_CG = 4'h3;
	localparam logic [15:0] SP_RESET = 16'h0280;
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [15:0] CG_VALUE = 16'h0000;
	localparam logic [15:0] BYTE_MASK = 16'h00FF;
	localparam logic [3:0] OP_MOV = 4'h4;
	localparam logic [3:0] OP_ADD = 4'h5;
	localparam logic [2:0] OP_JUMP_TAG = 3'h1;
	localparam logic [3:0] OP_SINGLE_TAG = 4'h1;
	localparam int unsigned OP_BYTE_BIT = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {FMT_DUAL, FMT_SINGLE, FMT_JUMP} cslp_fmt_t;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} cslp_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cslp_axi_rsp_t;
	typedef struct packed {
		logic main_clock_run;
		logic peripheral_subsystem_clock_run;
		logic aux_clock_tick;
		logic dc_generator_on;
		logic digital_osc_clock_on;
		logic crystal_osc_on;
	} cslp_clk_t;
endpackage

/* dv/cslp_core_test.sv */
// Self-checking bench for the status word and low-power clock control block
`timescale 1ns/100ps
module cslp_core_test;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	cslp_pkg::cslp_axi_req_t rq = '0;
	cslp_pkg::cslp_axi_rsp_t rs;
	logic irq_pin = 1'b0;
	logic xtal_pin = 1'b0;
	cslp_pkg::cslp_clk_t gates;
	cslp_pkg::cslp_clk_t gates_keep;
	logic irq_ack;
	logic [5:0] g;
	int fail_count = 0;
	int n_checks = 0;
	assign g = gates;
	always #25 clk = ~clk;
	cslp_core i_cslp_core (
		.clk(clk),
		.sys_rst(sys_rst),
		.axi_in(rq),
		.axi_out(rs),
		.irq_pin(irq_pin),
		.xtal_pin(xtal_pin),
		.gates(gates),
		.irq_ack(irq_ack)
	);
	// Build that forbids stopping the crystal, fed the same stimulus
	cslp_core #(.XTAL_OFF_ALLOWED(1'b0)) i_cslp_core_keep (
		.clk(clk), .sys_rst(sys_rst), .axi_in(rq), .axi_out(), .irq_pin(irq_pin),
		.xtal_pin(xtal_pin), .gates(gates_keep), .irq_ack()
	);
	// ====================================================================
	// Shared tasks
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// Aux tick bit pulses on rising crystal pin edges, so callers mask it
	task automatic chk_g(input logic [5:0] exp, input logic [5:0] m, input string msg);
		n_checks++;
		if ((g & m) !== (exp & m)) begin
			fail_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, g, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic [1:0] r;
		r = 2'h3;
		@(posedge clk);
		rq.awvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wvalid <= 1'b1;
		rq.wdata <= {16'h0000, d};
		rq.wstrb <= 4'hF;
		rq.bready <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
			if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
			if (rs.bvalid) begin
				r = rs.bresp;
				break;
			end
		end
		rq.bready <= 1'b0;
		chk({30'h0, r}, {30'h0, er}, "write response");
	endtask
	task automatic wrk(input logic [7:0] a, input logic [15:0] d);
		wr(a, d, cslp_pkg::RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'h3;
		d = 32'hDEAD_BEEF;
		@(posedge clk);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		rq.rready <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
			if (rs.rvalid) begin
				r = rs.rresp;
				d = rs.rdata;
				break;
			end
		end
		rq.rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk({30'h0, r}, {30'h0, cslp_pkg::RESP_OKAY}, "read response");
		chk(d, exp, msg);
	endtask
	task automatic ticks(output int n);
		n = 0;
		for (int i = 0; i < 56; i++) begin
			@(posedge clk);
			xtal_pin <= (i < 48) ? i[2] : 1'b0;
			if (g[3] === 1'b1) n++;
		end
	endtask
	// ====================================================================
	// Scenarios
	task automatic t_reset;
		rdchk(8'h48, 32'h0000_0000, "status reset");
		rdchk(8'h44, 32'h0000_0280, "stack pointer reset");
		rdchk(8'h10, 32'h0000_0077, "clock status reset");
		chk_g(6'h37, 6'h37, "gates after reset");
	endtask
	task automatic t_gate;
		logic [15:0] sw[4] = '{16'h0010, 16'h0040, 16'h0090, 16'h00D0};
		logic [5:0] ex[4] = '{6'h15, 6'h37, 6'h05, 6'h01};
		for (int i = 0; i < 4; i++) begin
			wrk(8'h48, sw[i]);
			cyc(3);
			chk_g(ex[i], 6'h37, "gate pattern");
		end
		wrk(8'h48, 16'h0000);
		cyc(3);
		chk_g(6'h00, 6'h20, "cpu clock waits for restart");
		cyc(40);
		chk_g(6'h37, 6'h37, "all running again");
	endtask
	task automatic t_xtal;
		int n;
		wrk(8'h48, 16'h0020);
		cyc(3);
		chk_g(6'h36, 6'h37, "crystal stopped");
		chk({31'h0, gates_keep.crystal_osc_on}, 32'd1, "crystal kept by build option");
		wrk(8'h04, 16'h0003);
		cyc(3);
		chk_g(6'h01, 6'h01, "crystal kept for main clock");
		wrk(8'h04, 16'h0004);
		cyc(3);
		chk_g(6'h01, 6'h01, "crystal kept for subsystem");
		wrk(8'h04, 16'h0000);
		cyc(3);
		ticks(n);
		chk(n, 32'd0, "no aux ticks while stopped");
		wrk(8'h48, 16'h0000);
		cyc(40);
		ticks(n);
		chk(n, 32'd6, "aux tick per crystal edge");
	endtask
	task automatic t_irq;
		wrk(8'h48, 16'h0018);
		cyc(3);
		irq_pin <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (irq_ack === 1'b1) break;
		end
		chk({31'h0, irq_ack}, 32'd1, "interrupt taken");
		irq_pin <= 1'b0;
		cyc(3);
		chk_g(6'h37, 6'h37, "woken from sleep");
		rdchk(8'h48, 32'h0000_0000, "status cleared on entry");
		rdchk(8'h08, 32'h0000_0018, "saved status");
		rdchk(8'h44, 32'h0000_027E, "stack pushed");
		wrk(8'h08, 16'h0098);
		wrk(8'h00, 16'h0001);
		cyc(3);
		rdchk(8'h48, 32'h0000_0098, "modified mode on return");
		rdchk(8'h44, 32'h0000_0280, "stack popped");
		chk_g(6'h05, 6'h37, "gates of new mode");
	endtask
	task automatic t_gie;
		int n;
		n = 0;
		wrk(8'h48, 16'h0010);
		irq_pin <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (irq_ack === 1'b1) n++;
		end
		irq_pin <= 1'b0;
		chk(n, 32'd0, "masked interrupt ignored");
		rdchk(8'h48, 32'h0000_0010, "mode kept while masked");
		cyc(4);
	endtask
	task automatic t_map;
		logic [31:0] d;
		logic [1:0] r;
		wrk(8'h48, 16'hFFFF);
		rdchk(8'h48, 32'h0000_01FF, "reserved bits read zero");
		wrk(8'h48, 16'h0000);
		rd(8'h20, d, r);
		chk({30'h0, r}, {30'h0, cslp_pkg::RESP_SLVERR}, "unmapped read");
		chk(d, 32'h0000_0000, "unmapped read data");
		wr(8'h24, 16'h1111, cslp_pkg::RESP_SLVERR);
	endtask
	task automatic t_ops;
		wrk(8'h54, 16'h1234);
		wrk(8'h0C, 16'h4504);
		rdchk(8'h50, 32'h0000_1234, "register move");
		wrk(8'h0C, 16'h5544);
		rdchk(8'h50, 32'h0000_0068, "byte add");
		wrk(8'h0C, 16'h2000);
		rdchk(8'h0C, 32'h0002_2000, "jump format");
		wrk(8'h0C, 16'h1000);
		rdchk(8'h0C, 32'h0001_1000, "single format");
		wrk(8'h4C, 16'h5555);
		rdchk(8'h4C, 32'h0000_0000, "constant register");
	endtask
	// ====================================================================
	// Sequence and watchdog
	initial begin
		cyc(8);
		sys_rst <= 1'b0;
		cyc(3);
		t_reset;
		t_gate;
		t_xtal;
		t_irq;
		t_gie;
		t_map;
		t_ops;
		stop_test;
	end
	// Whole run needs a few hundred cycles; this bound cuts a hang
	initial begin
		cyc(20000);
		fail_count++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		stop_test;
	end
endmodule
